// file: src/dlc_consts.svh
// Purpose: Offsets, field positions, codes and counts of the logger control
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Included by the top module
`ifndef DLC_CONSTS_SVH
`define DLC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DLC_OFS_CTRL       8'h00
`define DLC_OFS_STATUS     8'h04
`define DLC_OFS_ERR_CODE   8'h08
`define DLC_OFS_REC_COUNT  8'h0C
`define DLC_OFS_STORE_CMD  8'h10
`define DLC_OFS_SAMPLE_LIM 8'h14
`define DLC_OFS_PERIOD     8'h18
`define DLC_OFS_TRIG_SEL   8'h1C
`define DLC_OFS_CFG_COMMIT 8'h20
`define DLC_OFS_IRQ_STATUS 8'h24
`define DLC_OFS_IRQ_CLEAR  8'h28
`define DLC_OFS_IRQ_ENABLE 8'h2C

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define DLC_CTRL_RUN     0
`define DLC_CTRL_REQ     1
`define DLC_CTRL_CYCLIC  2
`define DLC_CTRL_TRIG    3

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define DLC_ST_PRESENT 0
`define DLC_ST_BUSY    1
`define DLC_ST_ERROR   2
`define DLC_ST_LIMIT   3
`define DLC_ST_VALID   4

// ----------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------
`define DLC_IRQ_RECORD 0
`define DLC_IRQ_LIMIT  1
`define DLC_IRQ_DONE   2
`define DLC_IRQ_ERROR  3

// ----------------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------------
`define DLC_STORE_CODE  16'h5AA5
`define DLC_STORE_IDLE  16'h0000
`define DLC_ERR_NO_CARD 16'h0001
`define DLC_MAX_POINTS  15'h4000
`define DLC_SEC_CYCLES  125000000

`endif

// file: src/dlc_pkg.sv
// Purpose: Types of the logger control
// Assumes: Constants come from dlc_consts.svh
// Notes:   Whole module state is one packed struct
package dlc_pkg;

	typedef enum logic [0:0] {
		DLC_IDLE  = 1'b0,
		DLC_STORE = 1'b1
	} dlc_store_e;

	typedef struct packed {
		logic        run;
		logic        req;
		logic        cyclic;
		logic        trig_mode;
		logic [15:0] cmd;
		logic [14:0] limit;
		logic [15:0] period;
		logic [12:0] trig_sel;
		logic        valid;
		logic [31:0] count;
		logic        lim_flag;
		logic [13:0] slot;
		logic [26:0] pre;
		logic [15:0] secs;
		logic        relay_prev;
		logic        req_prev;
		dlc_store_e  st;
		logic        err;
		logic [15:0] err_code;
		logic        cp_s1;
		logic        cp_s2;
		logic        cp_s3;
		logic        present;
		logic [3:0]  irq_st;
		logic [3:0]  irq_en;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq;
		logic        sample_stb;
	} dlc_state_s;

endpackage

// file: src/dlc_top.sv
// Purpose: Long-term data logger control with APB registers
// Assumes: Relay image and card writer run on sys_clk_i
// Notes:   Only the card-present pin is asynchronous
//
// Overview of operation
// - Records are taken while the run flag is set, none once cleared.
// - Hardware never clears the run flag, even when space is full.
// - A read-only 32-bit record count grows by one per stored record.
// - Limit flag rises when count reaches sample count, cyclic or not.
// - At the limit recording stops, or wraps over oldest records if cyclic.
// - Triggered mode samples on a rising edge of the chosen relay bit.
// - Parameters-valid flag is set by a valid commit, cleared by a sample-count or period write or a failed commit; a control write keeps it.
// - Store request rising with command 5AA5 starts a card store.
// - Command reads zero after a successful store; other values never start one.
// - A store also starts when the limit flag comes on with command 5AA5.
// - Card-present flag follows card insertion.
// - Store-busy flag is on for the whole card write.
// - A card error sets the error flag and latches the error code.
`include "dlc_consts.svh"

module dlc_top #(
	parameter int unsigned SEC_CYCLES = `DLC_SEC_CYCLES
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Interrupt
	output logic             irq_o,
	// Relay image
	output logic [12:0]      relay_sel_o,
	input  wire logic        relay_val_i,
	// Record store strobe
	output logic             sample_stb_o,
	output logic [13:0]      sample_slot_o,
	// Memory card
	input  wire logic        card_present_i,
	output logic             card_store_o,
	input  wire logic        card_done_i,
	input  wire logic        card_err_i,
	input  wire logic [15:0] card_err_code_i
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	dlc_pkg::dlc_state_s s;
	dlc_pkg::dlc_state_s next_s;

	logic        setup;
	logic        wr;
	logic [7:0]  a;
	logic        tick;
	logic        trig;
	logic        take;
	logic [31:0] cnt_inc;
	logic        lim_rise;
	logic        req_rise;
	logic        start;
	logic        cfg_ok;
	logic [3:0]  ev;
	logic [31:0] rd;
	logic        hit;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_s   = s;
		setup    = psel_i && !penable_i;
		wr       = psel_i && penable_i && s.pready && pwrite_i;
		a        = paddr_i;
		ev       = 4'h0;
		rd       = 32'h0000_0000;
		hit      = 1'b1;
		tick     = 1'b0;
		trig     = 1'b0;
		take     = 1'b0;
		lim_rise = 1'b0;
		start    = 1'b0;
		cnt_inc  = s.count + 32'h0000_0001;

		// Card-present pin, three stages
		next_s.cp_s1 = card_present_i;
		next_s.cp_s2 = s.cp_s1;
		next_s.cp_s3 = s.cp_s2;
		if (s.cp_s2 == s.cp_s3) begin
			next_s.present = s.cp_s3;
		end

		// Period timer and trigger edge
		next_s.relay_prev = relay_val_i;
		if (s.run && s.valid && !s.trig_mode) begin
			if (s.pre == 27'(SEC_CYCLES - 1)) begin
				next_s.pre = 27'h000_0000;
				if (s.secs + 16'h0001 >= s.period) begin
					next_s.secs = 16'h0000;
					tick = 1'b1;
				end else begin
					next_s.secs = s.secs + 16'h0001;
				end
			end else begin
				next_s.pre = s.pre + 27'h000_0001;
			end
		end else begin
			next_s.pre  = 27'h000_0000;
			next_s.secs = 16'h0000;
		end
		trig = s.trig_mode && relay_val_i && !s.relay_prev;

		// Record taking
		take = s.run && s.valid && (tick || trig)
			&& (!s.lim_flag || s.cyclic);
		next_s.sample_stb = take;
		if (take) begin
			next_s.count = cnt_inc;
			ev[`DLC_IRQ_RECORD] = 1'b1;
			if ({15'h0000, s.slot} + 29'h0000_0001 >= {14'h0000, s.limit}) begin
				next_s.slot = 14'h0000;
			end else begin
				next_s.slot = s.slot + 14'h0001;
			end
			if (cnt_inc >= {17'h0_0000, s.limit} && !s.lim_flag) begin
				next_s.lim_flag = 1'b1;
				lim_rise = 1'b1;
				ev[`DLC_IRQ_LIMIT] = 1'b1;
			end
		end

		// Card store sequence
		req_rise = s.req && !s.req_prev;
		next_s.req_prev = s.req;
		start = (s.cmd == `DLC_STORE_CODE)
			&& (req_rise || lim_rise);
		case (s.st)
			dlc_pkg::DLC_IDLE: begin
				if (start) begin
					if (s.present) begin
						next_s.st  = dlc_pkg::DLC_STORE;
						next_s.err = 1'b0;
					end else begin
						next_s.err      = 1'b1;
						next_s.err_code = `DLC_ERR_NO_CARD;
						ev[`DLC_IRQ_ERROR] = 1'b1;
					end
				end
			end
			dlc_pkg::DLC_STORE: begin
				if (card_err_i) begin
					next_s.st       = dlc_pkg::DLC_IDLE;
					next_s.err      = 1'b1;
					next_s.err_code = card_err_code_i;
					ev[`DLC_IRQ_ERROR] = 1'b1;
				end else if (card_done_i) begin
					next_s.st  = dlc_pkg::DLC_IDLE;
					next_s.cmd = `DLC_STORE_IDLE;
					ev[`DLC_IRQ_DONE] = 1'b1;
				end
			end
			default: begin
				next_s.st = dlc_pkg::DLC_IDLE;
			end
		endcase

		// Configuration check
		cfg_ok = (s.limit != 15'h0000) && (s.limit <= `DLC_MAX_POINTS)
			&& (s.trig_mode || s.period != 16'h0000);

		// Register writes
		if (wr) begin
			case (a)
				`DLC_OFS_CTRL: begin
					next_s.run       = pwdata_i[`DLC_CTRL_RUN];
					next_s.req       = pwdata_i[`DLC_CTRL_REQ];
					next_s.cyclic    = pwdata_i[`DLC_CTRL_CYCLIC];
					next_s.trig_mode = pwdata_i[`DLC_CTRL_TRIG];
				end
				`DLC_OFS_STORE_CMD: begin
					next_s.cmd = pwdata_i[15:0];
				end
				`DLC_OFS_SAMPLE_LIM: begin
					next_s.limit = pwdata_i[14:0];
					next_s.valid = 1'b0;
				end
				`DLC_OFS_PERIOD: begin
					next_s.period = pwdata_i[15:0];
					next_s.valid  = 1'b0;
				end
				`DLC_OFS_TRIG_SEL: begin
					next_s.trig_sel = pwdata_i[12:0];
				end
				`DLC_OFS_CFG_COMMIT: begin
					next_s.valid    = pwdata_i[0] && cfg_ok;
					next_s.count    = 32'h0000_0000;
					next_s.lim_flag = 1'b0;
					next_s.slot     = 14'h0000;
				end
				`DLC_OFS_IRQ_ENABLE: begin
					next_s.irq_en = pwdata_i[3:0];
				end
				default: begin
					next_s.irq_en = next_s.irq_en;
				end
			endcase
		end

		// Interrupt status, set wins over clear
		if (wr && a == `DLC_OFS_IRQ_CLEAR) begin
			next_s.irq_st = (s.irq_st & ~pwdata_i[3:0]) | ev;
		end else begin
			next_s.irq_st = s.irq_st | ev;
		end
		next_s.irq = |(next_s.irq_st & next_s.irq_en);

		// Register reads
		case (a)
			`DLC_OFS_CTRL: begin
				rd = {28'h000_0000, s.trig_mode, s.cyclic, s.req, s.run};
			end
			`DLC_OFS_STATUS: begin
				rd = {27'h000_0000, s.valid, s.lim_flag, s.err,
					s.st == dlc_pkg::DLC_STORE, s.present};
			end
			`DLC_OFS_ERR_CODE: begin
				rd = {16'h0000, s.err_code};
			end
			`DLC_OFS_REC_COUNT: begin
				rd = s.count;
			end
			`DLC_OFS_STORE_CMD: begin
				rd = {16'h0000, s.cmd};
			end
			`DLC_OFS_SAMPLE_LIM: begin
				rd = {17'h0_0000, s.limit};
			end
			`DLC_OFS_PERIOD: begin
				rd = {16'h0000, s.period};
			end
			`DLC_OFS_TRIG_SEL: begin
				rd = {19'h0_0000, s.trig_sel};
			end
			`DLC_OFS_CFG_COMMIT: begin
				rd = 32'h0000_0000;
			end
			`DLC_OFS_IRQ_STATUS: begin
				rd = {28'h000_0000, s.irq_st};
			end
			`DLC_OFS_IRQ_CLEAR: begin
				rd = 32'h0000_0000;
			end
			`DLC_OFS_IRQ_ENABLE: begin
				rd = {28'h000_0000, s.irq_en};
			end
			default: begin
				hit = 1'b0;
			end
		endcase

		// APB answer, one cycle after setup
		next_s.pready  = setup;
		next_s.pslverr = setup && !hit;
		if (setup) begin
			next_s.prdata = (hit && !pwrite_i) ? rd : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata_o      = s.prdata;
	assign pready_o      = s.pready;
	assign pslverr_o     = s.pslverr;
	assign irq_o         = s.irq;
	assign relay_sel_o   = s.trig_sel;
	assign sample_stb_o  = s.sample_stb;
	assign sample_slot_o = s.slot;
	assign card_store_o  = (s.st == dlc_pkg::DLC_STORE);

endmodule

// file: verification/dlc_top_sva.sv
// Purpose: Port assertions of the logger control
// Assumes: Zero-wait APB slave, registered outputs
// Notes:   Bound into every dlc_top
module dlc_top_sva #(
	parameter int unsigned SEC_CYCLES = 4
) (
	// Clock, reset and APB
	input wire logic        sys_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Logger and card
	input wire logic [12:0] relay_sel_o,
	input wire logic        sample_stb_o,
	input wire logic        card_store_o,
	input wire logic        card_done_i,
	input wire logic        card_err_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic acc;
	assign acc = psel_i && penable_i && pready_o;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// ----------
	// Assertions
	// ----------
	apb_ready_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("ready missing after setup");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (acc && paddr_i > 8'h2C |-> pslverr_o)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (acc && paddr_i <= 8'h2C
		&& paddr_i[1:0] == 2'h0 |-> !pslverr_o)
		else $error("error on mapped address");
	trig_sel_a: assert property (acc && pwrite_i && paddr_i == 8'h1C
		|=> relay_sel_o == $past(pwdata_i[12:0]))
		else $error("relay select not updated");
	store_hold_a: assert property (card_store_o && !card_done_i
		&& !card_err_i |=> card_store_o)
		else $error("store dropped early");
	store_end_a: assert property (card_store_o && (card_done_i
		|| card_err_i) |=> !card_store_o)
		else $error("store held after answer");
	run_stop_a: assert property (acc && pwrite_i && paddr_i == 8'h00
		&& !pwdata_i[0] |=> ##1 !sample_stb_o)
		else $error("record taken with run off");
endmodule

bind dlc_top dlc_top_sva #(.SEC_CYCLES(SEC_CYCLES)) i_sva (.sys_clk_i,
	.sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.pready_o, .pslverr_o, .relay_sel_o, .sample_stb_o, .card_store_o,
	.card_done_i, .card_err_i);

// file: verification/dlc_card_model.sv
// Purpose: Memory card model for the logger bench
// Assumes: One store at a time, answer after lat_i cycles
// Notes:   Code lines show the inverse outside a failure
module dlc_card_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Store handshake
	input  wire logic        store_i,
	input  wire logic        fail_i,
	input  wire logic [4:0]  lat_i,
	input  wire logic [15:0] code_i,
	output logic             done_o,
	output logic             err_o,
	output logic [15:0]      code_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       act;
	logic [4:0] cnt;
	assign code_o = err_o ? code_i : ~code_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			act <= 1'b0;
			cnt <= 5'h00;
			done_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			err_o <= 1'b0;
			if (act) begin
				cnt <= cnt - 5'h01;
				if (cnt == 5'h01) begin
					act <= 1'b0;
					err_o <= fail_i;
					done_o <= !fail_i;
				end
			end else if (store_i && !done_o && !err_o) begin
				act <= 1'b1;
				cnt <= lat_i;
			end
		end
	end
endmodule

// file: verification/dlc_top_tb.sv
// Purpose: Self-checking bench of the logger control
// Assumes: Zero-wait APB slave, one second shortened to 4 cycles
// Notes:   Reads queue their expectation, a monitor compares
module dlc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [31:0] m; logic [31:0] v; logic e;} dlc_note_s;
	dlc_note_s   notes[$];
	dlc_note_s   n;
	logic        sys_clk_i = 0;
	logic        sys_rst_i = 1;
	logic        psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic        pready_o, pslverr_o, irq_o, relay_val_i = 0;
	logic        sample_stb_o, card_present_i = 1, card_store_o;
	logic        card_done_i, card_err_i, fail = 0;
	logic [12:0] relay_sel_o, sel;
	logic [13:0] sample_slot_o;
	logic [15:0] card_err_code_i, code;
	logic [4:0]  lat = 5'h14;
	int          fail_count = 0, num_checks = 0, ticks = 0, gap = 0;
	dlc_top #(.SEC_CYCLES(4)) i_dut (.sys_clk_i, .sys_rst_i, .psel_i,
		.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
		.pslverr_o, .irq_o, .relay_sel_o, .relay_val_i, .sample_stb_o,
		.sample_slot_o, .card_present_i, .card_store_o, .card_done_i,
		.card_err_i, .card_err_code_i);
	dlc_card_model i_card (.clk_i(sys_clk_i), .rst_i(sys_rst_i),
		.store_i(card_store_o), .fail_i(fail), .lat_i(lat), .code_i(code),
		.done_o(card_done_i), .err_o(card_err_i), .code_o(card_err_code_i));
	initial begin
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		ticks++;
		if (ticks == 5000) begin
			fail_count++;
			wrap_up;
		end
	end
	always @(posedge sys_clk_i) begin
		if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
			n = notes.pop_front();
			num_checks++;
			if (((prdata_o ^ n.v) & n.m) !== 32'h0 || pslverr_o !== n.e) begin
				fail_count++;
				$display("BAD %0t read %h at %h", $time, prdata_o, paddr_i);
			end
		end
	end
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1;
		do @(posedge sys_clk_i); while (pready_o !== 1'b1);
		psel_i <= 0;
		penable_i <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, v,
			input logic e = 0);
		notes.push_back('{m, v, e});
		xfer(0, a, 32'h0);
	endtask
	task automatic chk(input logic g, e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t output %b not %b", $time, g, e);
		end
	endtask
	task automatic wait_store(input logic lvl);
		for (int i = 0; i < 40 && card_store_o !== lvl; i++)
			@(negedge sys_clk_i);
		chk(card_store_o, lvl);
	endtask
	task automatic pulse;
		@(posedge sys_clk_i);
		relay_val_i <= 1;
		repeat ($urandom_range(4, 1)) @(posedge sys_clk_i);
		relay_val_i <= 0;
		repeat (3) @(posedge sys_clk_i);
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(52720));
		sel = 13'($urandom);
		code = 16'($urandom) | 16'h8000;
		repeat (8) @(posedge sys_clk_i);
		sys_rst_i <= 0;
		repeat (6) @(posedge sys_clk_i);
		rd(8'h00, '1, 32'h0);
		rd(8'h0C, '1, 32'h0);
		rd(8'h04, '1, 32'h1);
		rd(8'h40, '1, 32'h0, 1);
		wr(8'h2C, 32'hF);
		wr(8'h14, 32'h3);
		wr(8'h18, 32'h1);
		wr(8'h1C, 32'(sel));
		wr(8'h00, 32'h9);
		wr(8'h20, 32'h1);
		wr(8'h10, 32'h5AA5);
		rd(8'h04, 32'h10, 32'h10);
		repeat (3) pulse;
		wait_store(1);
		wait_store(0);
		pulse;
		rd(8'h0C, '1, 32'h3);
		rd(8'h04, 32'h1F, 32'h19);
		rd(8'h00, '1, 32'h9);
		rd(8'h10, '1, 32'h0);
		chk(irq_o, 1);
		wr(8'h28, 32'hF);
		rd(8'h24, '1, 32'h0);
		chk(irq_o, 0);
		wr(8'h10, 32'h1234);
		wr(8'h00, 32'hB);
		repeat (8) @(negedge sys_clk_i);
		chk(card_store_o, 0);
		fail = 1;
		lat = 5'($urandom_range(12, 6));
		chk(irq_o, 0);
		wr(8'h10, 32'h5AA5);
		wr(8'h00, 32'h9);
		wr(8'h00, 32'hB);
		wait_store(1);
		rd(8'h04, 32'h2, 32'h2);
		wait_store(0);
		rd(8'h04, 32'h4, 32'h4);
		rd(8'h08, '1, 32'(code));
		@(posedge sys_clk_i);
		card_present_i <= 0;
		wr(8'h10, 32'h5AA5);
		wr(8'h00, 32'h9);
		wr(8'h00, 32'hB);
		rd(8'h04, 32'h7, 32'h4);
		rd(8'h08, '1, 32'h1);
		chk(card_store_o, 0);
		wr(8'h2C, 32'h0);
		wr(8'h20, 32'h1);
		rd(8'h0C, '1, 32'h0);
		rd(8'h04, 32'h18, 32'h10);
		wr(8'h00, 32'h8);
		pulse;
		rd(8'h0C, '1, 32'h0);
		wr(8'h00, 32'h9);
		pulse;
		rd(8'h0C, '1, 32'h1);
		rd(8'h24, 32'h1, 32'h1);
		chk(irq_o, 0);
		wr(8'h00, 32'h4);
		wr(8'h14, 32'h2);
		wr(8'h18, 32'h2);
		wr(8'h20, 32'h1);
		wr(8'h00, 32'h5);
		for (int i = 0; i < 3; i++) begin
			gap = 0;
			do begin
				@(posedge sys_clk_i);
				gap++;
			end while (sample_stb_o !== 1'b1);
		end
		num_checks++;
		if (gap != 8) begin
			fail_count++;
			$display("BAD %0t record gap %0d", $time, gap);
		end
		wr(8'h00, 32'h4);
		repeat (2) @(posedge sys_clk_i);
		rd(8'h0C, '1, 32'h3);
		rd(8'h04, 32'h18, 32'h18);
		num_checks++;
		if (sample_slot_o !== 14'h0001) begin
			fail_count++;
			$display("BAD %0t slot %h", $time, sample_slot_o);
		end
		wrap_up;
	end
endmodule
